/* File: axis_fault_encoder_supervisor.sv */
// Purpose: Per-axis driver status, encoder counter, deviation stop, standby
//          current control, command grouping and shaft reversal.
// Assumes: Driver fault and encoder pins are asynchronous; ramp, speed and
//          step signals come from logic on the same clock.
// Notes:   Register reads answer one cycle after the strobe.
// Operation
// - Status bits 0-2: stall, overtemp, prewarning
// - Bits 3/4: coil A/B short to ground
// - Bits 5/6: coil A/B open load
// - Bit 7: no step for 2^20 cycles
// - Negative counts-per-rev reverses encoder counting
// - Stop when position deviation exceeds limit
// - Zero position limit disables the check
// - Stop on velocity deviation; zero disables
// - Standby current after delay in 10 ms
// - Grouped axes copy motion commands
// - Group index zero never joins grouping
// - Shaft reverse inverts motor direction
// - Shaft reverse leaves encoder direction alone
// - Extended flags clear on read or command
//
// Our own choice: strobed register access.
`timescale 1ns/1ns

module axis_fault_encoder_supervisor
    import axis_supervisor_pkg::*;
#(
    parameter int STILL_LEN = STILL_CYCLES,
    parameter int TICK_LEN  = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Register port
    input  wire logic [ADDR_W-1:0]             addr,
    input  wire logic [31:0]                   wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [31:0]                   rdata,
    output logic                               irq,
    // Driver stage and encoder pins
    input  wire logic [NUM_AXES-1:0][FAULT_W-1:0] fault_pin,
    input  wire logic [NUM_AXES-1:0]           enc_a,
    input  wire logic [NUM_AXES-1:0]           enc_b,
    // Motion generator
    input  wire logic [NUM_AXES-1:0]           axis_enable,
    input  wire logic [NUM_AXES-1:0]           step_pulse,
    input  wire logic [NUM_AXES-1:0]           dir_request,
    input  wire logic [NUM_AXES-1:0][31:0]     actual_position,
    input  wire logic [NUM_AXES-1:0][31:0]     target_speed,
    input  wire logic [NUM_AXES-1:0][31:0]     measured_speed,
    // Command entry
    input  wire logic                          cmd_valid,
    input  wire logic [1:0]                    cmd_axis,
    input  wire cmd_t                          cmd_code,
    // Axis outputs
    output logic      [NUM_AXES-1:0]           axis_cmd_valid,
    output cmd_t                               axis_cmd_code,
    output logic      [NUM_AXES-1:0]           motor_stop,
    output logic      [NUM_AXES-1:0]           standby_current,
    output logic      [NUM_AXES-1:0]           motor_dir
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_AXES-1:0][FAULT_W-1:0] flt_s1;
        logic [NUM_AXES-1:0][FAULT_W-1:0] flt_s2;
        logic [NUM_AXES-1:0][1:0]         enc_s1;
        logic [NUM_AXES-1:0][1:0]         enc_s2;
        logic [NUM_AXES-1:0][1:0]         enc_prev;
        logic [NUM_AXES-1:0][31:0]        enc;
        logic [NUM_AXES-1:0][31:0]        cpr;
        logic [NUM_AXES-1:0][31:0]        plim;
        logic [NUM_AXES-1:0][31:0]        vlim;
        logic [NUM_AXES-1:0][15:0]        sdelay;
        logic [NUM_AXES-1:0][7:0]         grp;
        logic [NUM_AXES-1:0]              inv;
        logic [NUM_AXES-1:0][20:0]        idle;
        logic [NUM_AXES-1:0][15:0]        ticks;
        logic [NUM_AXES-1:0]              standby;
        logic [NUM_AXES-1:0][1:0]         ext;
        logic [NUM_AXES-1:0]              dev_stop;
        logic [NUM_AXES-1:0]              cmd_v;
        cmd_t                             cmd_c;
        logic [NUM_AXES-1:0]              dir;
        logic [2*NUM_AXES-1:0]            ist;
        logic [2*NUM_AXES-1:0]            imask;
        logic [19:0]                      tick_cnt;
        logic                             tick;
        logic [31:0]                      rdata;
    } state_t;

    state_t q;
    state_t next_q;

    // Address split
    logic [1:0] page;
    logic [7:0] idx;
    assign page = addr[ADDR_W-1:ADDR_W-2];
    assign idx  = addr[ADDR_W-3:2];

    // ****************************************************************
    // Per-axis checks and quadrature decoding
    // ****************************************************************
    logic [NUM_AXES-1:0]             pos_over;
    logic [NUM_AXES-1:0]             vel_over;
    logic [NUM_AXES-1:0]             enc_up;
    logic [NUM_AXES-1:0]             enc_dn;
    logic [NUM_AXES-1:0]             still;
    logic [NUM_AXES-1:0]             grp_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : gen_axis
            logic signed [32:0] pdiff;
            logic signed [32:0] vdiff;
            logic        [32:0] pmag;
            logic        [32:0] vmag;
            // Deviation magnitudes, one bit wider to avoid overflow
            assign pdiff = $signed({actual_position[g][31], actual_position[g]})
                         - $signed({q.enc[g][31], q.enc[g]});
            assign vdiff = $signed({target_speed[g][31], target_speed[g]})
                         - $signed({measured_speed[g][31], measured_speed[g]});
            assign pmag  = pdiff[32] ? 33'(-pdiff) : 33'(pdiff);
            assign vmag  = vdiff[32] ? 33'(-vdiff) : 33'(vdiff);
            assign pos_over[g] = (q.plim[g] != 32'h0) && (pmag > {1'b0, q.plim[g]});
            assign vel_over[g] = (q.vlim[g] != 32'h0) && (vmag > {1'b0, q.vlim[g]});

            // Gray-sequence decoding of A/B: forward is 00-01-11-10
            assign enc_up[g] = (q.enc_prev[g] ^ q.enc_s2[g]) != 2'h0
                             && (q.enc_prev[g][1] ^ q.enc_s2[g][0]);
            assign enc_dn[g] = (q.enc_prev[g] ^ q.enc_s2[g]) != 2'h0
                             && !(q.enc_prev[g][1] ^ q.enc_s2[g][0]);
            assign still[g] = q.idle[g] >= 21'(STILL_LEN);

            // Axis receives a command aimed at it or at a group partner
            assign grp_hit[g] = (cmd_axis == 2'(g))
                              || (q.grp[g] != GROUP_RST
                                  && q.grp[g] == q.grp[cmd_axis]);
        end
    endgenerate

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic cmd_ok;
        logic [NUM_AXES-1:0] cmd_hit;
        next_q   = q;
        cmd_ok   = cmd_valid && cmd_code != cmd_none && cmd_axis < 2'(NUM_AXES);
        cmd_hit  = '0;

        // Shared 10 ms timebase
        next_q.tick = 1'b0;
        if (q.tick_cnt >= 20'(TICK_LEN - 1)) begin
            next_q.tick_cnt = 20'h0;
            next_q.tick     = 1'b1;
        end else begin
            next_q.tick_cnt = q.tick_cnt + 20'h1;
        end

        next_q.rdata = 32'h0;
        for (int a = 0; a < NUM_AXES; a++) begin
            // Pin synchronisers
            next_q.flt_s1[a]   = fault_pin[a];
            next_q.flt_s2[a]   = q.flt_s1[a];
            next_q.enc_s1[a]   = {enc_a[a], enc_b[a]};
            next_q.enc_s2[a]   = q.enc_s1[a];
            next_q.enc_prev[a] = q.enc_s2[a];

            // Encoder counting, sign of counts-per-rev only
            if (enc_up[a] ^ q.cpr[a][31] && (enc_up[a] || enc_dn[a])) begin
                next_q.enc[a] = q.enc[a] + 32'h1;
            end else if (enc_up[a] || enc_dn[a]) begin
                next_q.enc[a] = q.enc[a] - 32'h1;
            end

            // Standstill span and standby delay
            if (step_pulse[a]) begin
                next_q.idle[a]    = 21'h0;
                next_q.ticks[a]   = 16'h0;
                next_q.standby[a] = 1'b0;
            end else begin
                if (!still[a]) next_q.idle[a] = q.idle[a] + 21'h1;
                if (q.tick && q.ticks[a] != 16'hFFFF) next_q.ticks[a] = q.ticks[a] + 16'h1;
                next_q.standby[a] = q.ticks[a] >= q.sdelay[a];
            end

            // Command fan-out to the addressed axis and its group
            cmd_hit[a]       = cmd_ok && grp_hit[a];
            next_q.cmd_v[a]  = cmd_hit[a];
            next_q.dir[a]    = dir_request[a] ^ q.inv[a];

            // Extended flags: command or read clears, new event wins
            if (cmd_hit[a]) begin
                next_q.ext[a]      = 2'h0;
                next_q.dev_stop[a] = 1'b0;
            end
            if (rd && page == 2'(a) && idx == IDX_EXT_ERR) begin
                next_q.rdata       = {30'h0, q.ext[a]};
                next_q.ext[a]      = 2'h0;
            end
            if (q.flt_s2[a][FLT_STALL]) begin
                next_q.ext[a][EXT_STALL] = 1'b1;
                next_q.ist[2*a]          = 1'b1;
            end
            if (axis_enable[a] && (pos_over[a] || vel_over[a])) begin
                next_q.dev_stop[a]     = 1'b1;
                next_q.ext[a][EXT_DEV] = 1'b1;
                next_q.ist[2*a+1]      = 1'b1;
            end

            // Register writes; status word has no write path
            if (wr && page == 2'(a)) begin
                unique case (idx)
                    IDX_ENC_COUNT:  next_q.enc[a]    = wdata;
                    IDX_ENC_CPR:    next_q.cpr[a]    = wdata;
                    IDX_POS_LIMIT:  next_q.plim[a]   = {1'b0, wdata[30:0]};
                    IDX_VEL_LIMIT:  next_q.vlim[a]   = {1'b0, wdata[30:0]};
                    IDX_STBY_DELAY: next_q.sdelay[a] = wdata[15:0];
                    IDX_GROUP:      next_q.grp[a]    = wdata[7:0];
                    IDX_INVERT:     next_q.inv[a]    = wdata[0];
                    default:        ;
                endcase
            end

            // Register reads
            if (rd && page == 2'(a)) begin
                unique case (idx)
                    IDX_FAULT_FLAGS: next_q.rdata = {24'h0, still[a], q.flt_s2[a]};
                    IDX_ENC_COUNT:   next_q.rdata = q.enc[a];
                    IDX_ENC_CPR:     next_q.rdata = q.cpr[a];
                    IDX_POS_LIMIT:   next_q.rdata = q.plim[a];
                    IDX_VEL_LIMIT:   next_q.rdata = q.vlim[a];
                    IDX_STBY_DELAY:  next_q.rdata = {16'h0, q.sdelay[a]};
                    IDX_GROUP:       next_q.rdata = {24'h0, q.grp[a]};
                    IDX_INVERT:      next_q.rdata = {31'h0, q.inv[a]};
                    IDX_EXT_ERR:     next_q.rdata = {30'h0, q.ext[a]};
                    default:         next_q.rdata = 32'h0;
                endcase
            end
        end

        next_q.cmd_c = cmd_ok ? cmd_code : cmd_none;

        // Global page: interrupt status clears on read, set wins
        if (rd && page == GLOBAL_PAGE && idx == IDX_IRQ_STATUS) begin
            next_q.rdata = {26'h0, q.ist};
            for (int b = 0; b < 2*NUM_AXES; b++) begin
                next_q.ist[b] = 1'b0;
            end
            for (int a = 0; a < NUM_AXES; a++) begin
                if (q.flt_s2[a][FLT_STALL]) next_q.ist[2*a] = 1'b1;
                if (axis_enable[a] && (pos_over[a] || vel_over[a])) next_q.ist[2*a+1] = 1'b1;
            end
        end

        if (rd && page == GLOBAL_PAGE && idx == IDX_IRQ_MASK) begin
            next_q.rdata = {26'h0, q.imask};
        end
        if (wr && page == GLOBAL_PAGE && idx == IDX_IRQ_MASK) begin
            next_q.imask = wdata[2*NUM_AXES-1:0];
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q        <= '0;
            q.sdelay <= {NUM_AXES{STBY_DELAY_RST}};
            q.grp    <= {NUM_AXES{GROUP_RST}};
            q.cmd_c  <= cmd_none;
        end else begin
            q <= next_q;
        end
    end

    // Outputs
    assign rdata           = q.rdata;
    assign irq             = |(q.ist & q.imask);
    assign axis_cmd_valid  = q.cmd_v;
    assign axis_cmd_code   = q.cmd_c;
    assign motor_stop      = q.dev_stop;
    assign standby_current = q.standby;
    assign motor_dir       = q.dir;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Status word
    a_fault_word_map: assert property (##2 q.flt_s2[0] == $past(fault_pin[0], 2))
        else $error("fault word bits do not follow driver pins");

    a_short_open_bits: assert property (
        ##2 q.flt_s2[1][6:3] == $past(fault_pin[1][6:3], 2))
        else $error("short or open-load bits lost");

    a_open_load_bits: assert property (
        ##2 q.flt_s2[2][6:5] == $past(fault_pin[2][6:5], 2))
        else $error("open-load bits lost");

    a_standstill_clear: assert property (step_pulse[0] |=> !still[0])
        else $error("standstill bit set after a step");

    // Encoder direction
    a_encoder_reverse: assert property (
        enc_up[0] && q.cpr[0][31] && !wr |=> q.enc[0] == $past(q.enc[0]) - 32'h1)
        else $error("negative resolution did not reverse counting");

    a_encoder_forward: assert property (
        enc_up[0] && !q.cpr[0][31] && !wr |=> q.enc[0] == $past(q.enc[0]) + 32'h1)
        else $error("encoder counted the wrong way");

    // Deviation stop
    a_pos_dev_stop: assert property (
        axis_enable[0] && pos_over[0] && !cmd_valid |=> motor_stop[0] && q.ext[0][EXT_DEV])
        else $error("position deviation did not stop motor");

    a_zero_limit_off: assert property (
        q.plim[0] == 32'h0 && !vel_over[0] |=> !$rose(motor_stop[0]))
        else $error("zero limit still checks deviation");

    a_vel_dev_stop: assert property (
        axis_enable[1] && vel_over[1] && !cmd_valid |=> motor_stop[1])
        else $error("velocity deviation did not stop motor");

    // Standby current
    a_standby_delay: assert property (
        $rose(standby_current[0]) |-> $past(q.ticks[0]) >= $past(q.sdelay[0]))
        else $error("standby entered before delay");

    a_standby_clear: assert property (step_pulse[2] |=> !standby_current[2])
        else $error("standby kept after a step");

    // Command grouping
    a_group_copy: assert property (
        cmd_valid && cmd_code != cmd_none && cmd_axis == 2'h0 && q.grp[0] != 8'h0
        && q.grp[1] == q.grp[0] |=> axis_cmd_valid[1] && axis_cmd_valid[0])
        else $error("grouped axis missed a command");

    a_group_zero_out: assert property (
        cmd_valid && cmd_axis == 2'h0 && q.grp[2] == 8'h0 |=> !axis_cmd_valid[2])
        else $error("ungrouped axis took a command");

    // Shaft and flags
    a_dir_invert: assert property (##1 motor_dir == $past(dir_request ^ q.inv))
        else $error("shaft reverse not applied");

    a_ext_read_clear: assert property (
        rd && page == 2'h0 && idx == IDX_EXT_ERR && !q.flt_s2[0][FLT_STALL]
        && !(axis_enable[0] && (pos_over[0] || vel_over[0])) |=> q.ext[0] == 2'h0)
        else $error("extended flags not cleared by read");

    a_stall_ext_flag: assert property (q.flt_s2[0][FLT_STALL] |=> q.ext[0][EXT_STALL])
        else $error("stall flag not set");

    // Main scenarios
    c_dev_stop: cover property ($rose(motor_stop[0]));
    c_group_cmd: cover property (axis_cmd_valid[0] && axis_cmd_valid[1]);
    c_irq_raise: cover property ($rose(irq));
    c_standby: cover property ($rose(standby_current[2]));
    c_vel_stop: cover property ($rose(motor_stop[1]));

endmodule

/* File: axis_supervisor_pkg.sv */
// Purpose: Shared constants and types for the axis fault, encoder and
//          standstill supervisor.
// Assumes: Three axes, 32-bit register words, 100 MHz clock.
// Notes:   Byte address = {axis, index, 2'b00}; axis 3 holds global registers.

package axis_supervisor_pkg;

    // ****************************************************************
    // Structure and clock
    // ****************************************************************
    localparam int NUM_AXES      = 3;
    localparam int ADDR_W        = 12;
    localparam int CLK_MHZ       = 100;
    localparam int FAULT_W       = 7;
    localparam int TICK_MS       = 10;                   // Standby delay unit
    localparam int TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;
    localparam int STILL_CYCLES  = 2 ** 20;              // Step-free span for standstill

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_EXT_ERR     = 8'hCF;
    localparam logic [7:0] IDX_FAULT_FLAGS = 8'hD0;
    localparam logic [7:0] IDX_ENC_COUNT   = 8'hD1;
    localparam logic [7:0] IDX_ENC_CPR     = 8'hD2;
    localparam logic [7:0] IDX_POS_LIMIT   = 8'hD4;
    localparam logic [7:0] IDX_VEL_LIMIT   = 8'hD5;
    localparam logic [7:0] IDX_STBY_DELAY  = 8'hD6;
    localparam logic [7:0] IDX_GROUP       = 8'hF9;
    localparam logic [7:0] IDX_INVERT      = 8'hFB;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h00;      // Global page
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h01;      // Global page
    localparam logic [1:0] GLOBAL_PAGE     = 2'h3;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int FLT_STALL   = 0;
    localparam int FLT_STILL   = 7;
    localparam int EXT_STALL   = 0;                      // Reads as value 1
    localparam int EXT_DEV     = 1;                      // Reads as value 2
    localparam logic [15:0] STBY_DELAY_RST = 16'h00C8;
    localparam logic [7:0]  GROUP_RST      = 8'h00;

    // ****************************************************************
    // Motion commands
    // ****************************************************************
    typedef enum logic [2:0] {
        cmd_none,
        rotate_right_cmd,
        rotate_left_cmd,
        motor_stop_cmd,
        move_to_position_cmd,
        reference_search_cmd
    } cmd_t;

endpackage

/* File: driver_encoder_model.sv */
// Purpose: Driver stage and quadrature encoder standing at the far side.
// Assumes: Bench requests change just after the rising clock edge.
// Notes:   Encoder moves forward only, Gray order 00,01,11,10.
`timescale 1ns/1ns

module driver_encoder_model
    import axis_supervisor_pkg::*;
(
    // Clock and reset
    input  wire logic                             clock,
    input  wire logic                             rst,
    // Bench requests
    input  wire logic [NUM_AXES-1:0][FAULT_W-1:0] fault_req,
    input  wire logic [NUM_AXES-1:0]              step_fwd,
    // Pins toward the supervisor
    output logic      [NUM_AXES-1:0][FAULT_W-1:0] fault_pin,
    output logic      [NUM_AXES-1:0]              enc_a,
    output logic      [NUM_AXES-1:0]              enc_b
);
    // ****************************************************************
    // Driver flags and encoder phase
    // ****************************************************************
    logic [NUM_AXES-1:0][1:0] phase;

    // Flags follow the request; phase moves one quarter per step
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_pin <= '0;
            phase     <= '0;
        end else begin
            fault_pin <= fault_req;
            for (int i = 0; i < NUM_AXES; i++) begin
                if (step_fwd[i]) begin
                    phase[i] <= phase[i] + 2'h1;
                end
            end
        end
    end

    // Gray coding of the phase onto the two channels
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            enc_a[i] = phase[i][1];
            enc_b[i] = phase[i][1] ^ phase[i][0];
        end
    end
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the axis supervisor.
// Assumes: Shortened standstill span (16) and tick (4 cycles).
// Notes:   Reset values first, then register rows, then hand-written awkward cases.
`timescale 1ns/1ns

module testbench
    import axis_supervisor_pkg::*;
;
    // ****************************************************************
    // Signals, partner and design
    // ****************************************************************
    typedef struct packed {logic [7:0] idx; logic [31:0] wv; logic [31:0] ex;} row_t;
    logic clock = 1'b0, rst, wr, rd, irq, cmd_valid;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [NUM_AXES-1:0][FAULT_W-1:0] fault_req, fault_pin;
    logic [NUM_AXES-1:0] step_fwd, enc_a, enc_b, axis_enable, step_pulse, dir_request;
    logic [NUM_AXES-1:0] axis_cmd_valid, motor_stop, standby_current, motor_dir;
    logic [NUM_AXES-1:0][31:0] actual_position, target_speed, measured_speed;
    logic [1:0] cmd_axis;
    cmd_t cmd_code, axis_cmd_code;
    int failures, n_tests;
    row_t rows [9] = '{
        '{IDX_ENC_COUNT, 32'h12345678, 32'h12345678}, '{IDX_ENC_CPR, 32'h00000FA0, 32'h00000FA0},
        '{IDX_POS_LIMIT, 32'hFFFFFFFF, 32'h7FFFFFFF}, '{IDX_VEL_LIMIT, 32'h80000005, 32'h00000005},
        '{IDX_STBY_DELAY, 32'h00012345, 32'h00002345}, '{IDX_GROUP, 32'h000001FF, 32'h000000FF},
        '{IDX_INVERT, 32'h00000003, 32'h00000001}, '{IDX_FAULT_FLAGS, 32'h0000007F, 32'h00000080},
        '{8'h10, 32'hFFFFFFFF, 32'h00000000}};

    driver_encoder_model model (.clock(clock), .rst(rst), .fault_req(fault_req),
        .step_fwd(step_fwd), .fault_pin(fault_pin), .enc_a(enc_a), .enc_b(enc_b));
    axis_fault_encoder_supervisor #(.STILL_LEN(16), .TICK_LEN(4)) dut (.clock(clock),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .fault_pin(fault_pin), .enc_a(enc_a), .enc_b(enc_b), .axis_enable(axis_enable),
        .step_pulse(step_pulse), .dir_request(dir_request), .actual_position(actual_position),
        .target_speed(target_speed), .measured_speed(measured_speed), .cmd_valid(cmd_valid),
        .cmd_axis(cmd_axis), .cmd_code(cmd_code), .axis_cmd_valid(axis_cmd_valid),
        .axis_cmd_code(axis_cmd_code), .motor_stop(motor_stop),
        .standby_current(standby_current), .motor_dir(motor_dir));

    // Clock generator
    always #5 clock = ~clock;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] ex);
        n_tests++;
        if (seen !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, ex, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic reg_write(input logic [1:0] ax, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clock);
        addr  <= {ax, idx, 2'b00};
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [1:0] ax, input logic [7:0] idx, input logic [31:0] ex,
                          input string name);
        @(posedge clock);
        addr <= {ax, idx, 2'b00};
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 chk(name, rdata, ex);
        @(posedge clock);
    endtask
    task automatic send(input logic [1:0] ax, input cmd_t c, input logic [2:0] ev, input cmd_t ec);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_axis  <= ax;
        cmd_code  <= c;
        @(posedge clock);
        cmd_valid <= 1'b0;
        #1 chk("cmd_valid", {29'h0, axis_cmd_valid}, {29'h0, ev});
        chk("cmd_code", {29'h0, axis_cmd_code}, {29'h0, ec});
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        failures++;
        stop_test;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {wr, rd, cmd_valid, addr, wdata, cmd_axis} = '0;
        {fault_req, step_fwd, axis_enable, step_pulse, dir_request} = '0;
        {actual_position, target_speed, measured_speed} = '0;
        cmd_code = cmd_none;
        rst = 1'b1;
        cyc(12);
        rst <= 1'b0;
        chk("stop_rst", {29'h0, motor_stop}, 32'h0);
        rd_chk(2'h0, IDX_STBY_DELAY, 32'h000000C8, "stby_rst");
        rd_chk(2'h1, IDX_GROUP, 32'h00000000, "group_rst");
        foreach (rows[i]) begin
            reg_write(2'h0, rows[i].idx, rows[i].wv);
            rd_chk(2'h0, rows[i].idx, rows[i].ex, "reg_row");
        end
        for (int b = 0; b < 7; b++) begin
            @(posedge clock);
            fault_req[0] <= 7'(1 << b);
            cyc(6);
            rd_chk(2'h0, IDX_FAULT_FLAGS, 32'h80 | (32'h1 << b), "fault");
            fault_req[0] <= '0;
        end
        chk("irq_masked", {31'h0, irq}, 32'h0);
        reg_write(GLOBAL_PAGE, IDX_IRQ_MASK, 32'h1);
        #1 chk("irq_on", {31'h0, irq}, 32'h1);
        rd_chk(GLOBAL_PAGE, IDX_IRQ_STATUS, 32'h1, "irq_status");
        chk("irq_off", {31'h0, irq}, 32'h0);
        rd_chk(2'h0, IDX_EXT_ERR, 32'h1, "ext_stall");
        rd_chk(2'h0, IDX_EXT_ERR, 32'h0, "ext_clear");
        @(posedge clock);
        step_pulse[0] <= 1'b1;
        @(posedge clock);
        step_pulse[0] <= 1'b0;
        cyc(3);
        rd_chk(2'h0, IDX_FAULT_FLAGS, 32'h0, "moving");
        cyc(20);
        rd_chk(2'h0, IDX_FAULT_FLAGS, 32'h80, "still");
        reg_write(2'h0, IDX_ENC_COUNT, 32'h0);
        for (int k = 0; k < 2; k++) begin
            repeat (4) begin
                @(posedge clock);
                step_fwd[0] <= 1'b1;
                @(posedge clock);
                step_fwd[0] <= 1'b0;
                cyc(3);
            end
            cyc(4);
            rd_chk(2'h0, IDX_ENC_COUNT, 32'h4 - 32'(4 * k), "enc_count");
            reg_write(2'h0, IDX_ENC_CPR, 32'h80000FA0);
        end
        dir_request <= '1;
        cyc(2);
        chk("motor_dir", {29'h0, motor_dir}, 32'h6);
        axis_enable <= 3'h3;
        reg_write(2'h0, IDX_POS_LIMIT, 32'h0);
        actual_position[0] <= 32'd1000;
        cyc(5);
        chk("pos_off", {29'h0, motor_stop}, 32'h0);
        actual_position[0] <= 32'd10;
        cyc(2);
        reg_write(2'h0, IDX_POS_LIMIT, 32'd10);
        cyc(5);
        chk("pos_edge", {29'h0, motor_stop}, 32'h0);
        actual_position[0] <= 32'd11;
        cyc(4);
        chk("pos_stop", {29'h0, motor_stop}, 32'h1);
        rd_chk(2'h0, IDX_EXT_ERR, 32'h2, "ext_dev");
        actual_position[0] <= 32'd0;
        cyc(2);
        send(2'h0, motor_stop_cmd, 3'h1, motor_stop_cmd);
        chk("stop_clear", {29'h0, motor_stop}, 32'h0);
        rd_chk(2'h0, IDX_EXT_ERR, 32'h0, "ext_cmd");
        target_speed[1]   <= 32'd100;
        measured_speed[1] <= 32'd50;
        for (int v = 0; v < 3; v++) begin
            reg_write(2'h1, IDX_VEL_LIMIT, (v == 0) ? 32'd0 : 32'd51 - 32'(v));
            cyc(5);
            chk("vel_stop", {29'h0, motor_stop}, (v == 2) ? 32'h2 : 32'h0);
        end
        measured_speed[1] <= 32'd100;
        reg_write(2'h0, IDX_GROUP, 32'h5);
        reg_write(2'h1, IDX_GROUP, 32'h5);
        for (int c = 1; c < 6; c++) begin
            send(2'h1, cmd_t'(c), 3'h3, cmd_t'(c));
        end
        send(2'h2, rotate_left_cmd, 3'h4, rotate_left_cmd);
        send(2'h3, rotate_right_cmd, 3'h0, cmd_none);
        reg_write(2'h2, IDX_STBY_DELAY, 32'h2);
        repeat (10) begin
            @(posedge clock);
            step_pulse[2] <= ~step_pulse[2];
        end
        cyc(3);
        chk("stby_early", {31'h0, standby_current[2]}, 32'h0);
        cyc(17);
        chk("stby_late", {31'h0, standby_current[2]}, 32'h1);
        stop_test;
    end
endmodule
